// >>> timer16_pkg.sv
// Purpose: shared constants for the 16-bit timer with capture and its CPU end
// Assumes: 8-bit CPU data bus, byte addresses on an 8-bit address bus
// Notes: each 16-bit register is a low/high byte pair, high at low + 1
package timer16_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int DIV_W = 10;

    // byte addresses
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h01;
    localparam logic [7:0] ADDR_CNT_L = 8'h04;
    localparam logic [7:0] ADDR_CNT_H = 8'h05;
    localparam logic [7:0] ADDR_CAP_L = 8'h06;
    localparam logic [7:0] ADDR_CAP_H = 8'h07;
    localparam logic [7:0] ADDR_CMPA_L = 8'h08;
    localparam logic [7:0] ADDR_CMPA_H = 8'h09;
    localparam logic [7:0] ADDR_CMPB_L = 8'h0A;
    localparam logic [7:0] ADDR_CMPB_H = 8'h0B;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0D;

    // control_reg_a fields
    localparam int WGM_LO_POS = 0;
    // control_reg_b fields
    localparam int CS_POS = 0;
    localparam int WGM_HI_POS = 3;
    localparam int TRIG_SRC_POS = 5;
    localparam int EDGE_RISE_POS = 6;
    // mask and flag register fields
    localparam int OVF_BIT = 0;
    localparam int CAP_BIT = 5;

    // clock_source_select values
    localparam logic [2:0] CS_NONE = 3'h0;
    localparam logic [2:0] CS_SYS = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03F;
    localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

    // fixed top values and extremes
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [1:0] {
        TOP_FIXED,
        TOP_CMPA,
        TOP_CAP
    } top_src_t;
endpackage : timer16_pkg

// >>> timer_bus_if.sv
// Purpose: 8-bit I/O bus between the CPU end and the timer
// Assumes: one clock shared by both ends, strobes one cycle wide
// Notes: read data answers one cycle after the read strobe
`timescale 1ns/1ps
interface timer_bus_if;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic wrStrobe;
    logic rdStrobe;
    logic capIrq;
    logic ovfIrq;
    logic capAck;
    logic ovfAck;

    modport device (
        input addr,
        input wrData,
        input wrStrobe,
        input rdStrobe,
        input capAck,
        input ovfAck,
        output rdData,
        output capIrq,
        output ovfIrq
    );

    modport cpu (
        output addr,
        output wrData,
        output wrStrobe,
        output rdStrobe,
        output capAck,
        output ovfAck,
        input rdData,
        input capIrq,
        input ovfIrq
    );
endinterface : timer_bus_if

// >>> timer16_device.sv
// Purpose: 16-bit up/down timer/counter with input capture on an 8-bit bus
// Assumes: pins come from outside the clock domain and are synchronised
// Notes: compare B is plain storage and compare A only sets top, no waveform outputs
`timescale 1ns/1ps
module timer16_device (
    input wire logic ref_clk,
    input wire logic rst_n,
    timer_bus_if.device bus,
    input wire logic capturePin,
    input wire logic comparatorOut,
    input wire logic extClockPin,
    output logic [timer16_pkg::CNT_W-1:0] countValue,
    output logic topReached,
    output logic bottomReached
);
    import timer16_pkg::*;

    logic [7:0] controlRegA, next_controlRegA;
    logic [7:0] controlRegB, next_controlRegB;
    logic [7:0] irqMask, next_irqMask;
    logic [15:0] count, next_count;
    logic [15:0] capture, next_capture;
    logic [15:0] compareA, next_compareA;
    logic [15:0] compareB, next_compareB;
    logic [7:0] temp, next_temp;
    logic [7:0] rdData, next_rdData;
    logic countUp, next_countUp;
    logic overflowFlag, next_overflowFlag;
    logic captureFlag, next_captureFlag;
    logic next_topReached, next_bottomReached;
    logic [DIV_W-1:0] divCnt, next_divCnt;
    logic [1:0] extSync, pinSync, cmpSync;
    logic extPrev, trigPrev;

    logic [3:0] waveformModeSelect;
    logic [2:0] clockSourceSelect;
    logic [15:0] top;
    top_src_t topSrc;
    logic dualSlope, ovfAtTop;
    logic timerTick, trigLevel, trigEdge, captureEvent;
    logic wrCntL, wrCapL, ovfSet;

    // the mode field is split: low two bits in A, high two in B
    assign waveformModeSelect = {controlRegB[WGM_HI_POS+1:WGM_HI_POS],
                                 controlRegA[WGM_LO_POS+1:WGM_LO_POS]};
    assign clockSourceSelect = controlRegB[CS_POS+2:CS_POS];

    always_comb begin
        topSrc = TOP_FIXED;
        top = CNT_MAX;
        dualSlope = 1'b0;
        ovfAtTop = 1'b0;
        case (waveformModeSelect)
            4'h1: begin top = TOP_8BIT; dualSlope = 1'b1; end
            4'h2: begin top = TOP_9BIT; dualSlope = 1'b1; end
            4'h3: begin top = TOP_10BIT; dualSlope = 1'b1; end
            4'h4: topSrc = TOP_CMPA;
            4'h5: begin top = TOP_8BIT; ovfAtTop = 1'b1; end
            4'h6: begin top = TOP_9BIT; ovfAtTop = 1'b1; end
            4'h7: begin top = TOP_10BIT; ovfAtTop = 1'b1; end
            4'h8, 4'hA: begin topSrc = TOP_CAP; dualSlope = 1'b1; end
            4'h9, 4'hB: begin topSrc = TOP_CMPA; dualSlope = 1'b1; end
            4'hC: topSrc = TOP_CAP;
            4'hE: begin topSrc = TOP_CAP; ovfAtTop = 1'b1; end
            4'hF: begin topSrc = TOP_CMPA; ovfAtTop = 1'b1; end
            default: topSrc = TOP_FIXED;
        endcase
        if (topSrc == TOP_CMPA) begin
            top = compareA;
        end else if (topSrc == TOP_CAP) begin
            top = capture;
        end
    end

    // timer tick: prescaler taps or synchronised external edge
    always_comb begin
        case (clockSourceSelect)
            CS_NONE: timerTick = 1'b0;
            CS_SYS: timerTick = 1'b1;
            CS_DIV8: timerTick = (divCnt & PRE_MASK_8) == PRE_MASK_8;
            CS_DIV64: timerTick = (divCnt & PRE_MASK_64) == PRE_MASK_64;
            CS_DIV256: timerTick = (divCnt & PRE_MASK_256) == PRE_MASK_256;
            CS_DIV1024: timerTick = divCnt == PRE_MASK_1024;
            CS_EXT_FALL: timerTick = extPrev & ~extSync[1];
            default: timerTick = ~extPrev & extSync[1];
        endcase
    end

    // capture input is switched off while the capture register is top
    assign trigLevel = controlRegB[TRIG_SRC_POS] ? cmpSync[1] : pinSync[1];
    assign trigEdge = controlRegB[EDGE_RISE_POS] ? (trigLevel & ~trigPrev)
                                                 : (~trigLevel & trigPrev);
    assign captureEvent = trigEdge & (topSrc != TOP_CAP);

    assign wrCntL = bus.wrStrobe && bus.addr == ADDR_CNT_L;
    assign wrCapL = bus.wrStrobe && bus.addr == ADDR_CAP_L;

    always_comb begin
        next_controlRegA = controlRegA;
        next_controlRegB = controlRegB;
        next_irqMask = irqMask;
        next_count = count;
        next_capture = capture;
        next_compareA = compareA;
        next_compareB = compareB;
        next_temp = temp;
        next_rdData = rdData;
        next_countUp = countUp;
        next_overflowFlag = overflowFlag;
        next_captureFlag = captureFlag;
        next_topReached = 1'b0;
        next_bottomReached = 1'b0;
        ovfSet = 1'b0;
        next_divCnt = (clockSourceSelect == CS_NONE) ? '0 : divCnt + 1'b1;

        // counting; a CPU write below replaces the result
        if (timerTick) begin
            next_topReached = count == top;
            next_bottomReached = count == CNT_BOTTOM;
            if (dualSlope) begin
                if (countUp && count >= top) begin
                    next_countUp = 1'b0;
                    next_count = count - 1'b1;
                end else if (!countUp && count == CNT_BOTTOM) begin
                    next_countUp = 1'b1;
                    next_count = count + 1'b1;
                    ovfSet = 1'b1;
                end else if (countUp) begin
                    next_count = count + 1'b1;
                end else begin
                    next_count = count - 1'b1;
                end
            end else begin
                next_countUp = 1'b1;
                next_count = (count == top) ? CNT_BOTTOM : count + 1'b1;
                if (ovfAtTop ? count == top : count == CNT_MAX) begin
                    ovfSet = 1'b1;
                end
            end
        end

        // a new capture simply overwrites an unread one
        if (captureEvent) begin
            next_capture = count;
        end

        // reads answer next cycle; count and capture low-byte reads latch the high byte
        if (bus.rdStrobe) begin
            if (bus.addr == ADDR_CTRL_A) begin
                next_rdData = controlRegA;
            end else if (bus.addr == ADDR_CTRL_B) begin
                next_rdData = controlRegB;
            end else if (bus.addr == ADDR_CNT_L) begin
                next_rdData = count[7:0];
                next_temp = count[15:8];
            end else if (bus.addr == ADDR_CNT_H || bus.addr == ADDR_CAP_H) begin
                next_rdData = temp;
            end else if (bus.addr == ADDR_CAP_L) begin
                next_rdData = capture[7:0];
                next_temp = capture[15:8];
            end else if (bus.addr == ADDR_CMPA_L) begin
                next_rdData = compareA[7:0];
            end else if (bus.addr == ADDR_CMPA_H) begin
                next_rdData = compareA[15:8];
            end else if (bus.addr == ADDR_CMPB_L) begin
                next_rdData = compareB[7:0];
            end else if (bus.addr == ADDR_CMPB_H) begin
                next_rdData = compareB[15:8];
            end else if (bus.addr == ADDR_IRQ_MASK) begin
                next_rdData = irqMask;
            end else if (bus.addr == ADDR_IRQ_FLAGS) begin
                next_rdData = 8'h00;
                next_rdData[OVF_BIT] = overflowFlag;
                next_rdData[CAP_BIT] = captureFlag;
            end else begin
                next_rdData = 8'h00;
            end
        end

        if (bus.wrStrobe) begin
            if (bus.addr == ADDR_CTRL_A) begin
                next_controlRegA = bus.wrData;
            end else if (bus.addr == ADDR_CTRL_B) begin
                next_controlRegB = bus.wrData;
            end else if (bus.addr == ADDR_CNT_H || bus.addr == ADDR_CAP_H ||
                         bus.addr == ADDR_CMPA_H ||
                         bus.addr == ADDR_CMPB_H) begin
                next_temp = bus.wrData;
            end else if (bus.addr == ADDR_CMPA_L) begin
                next_compareA = {temp, bus.wrData};
            end else if (bus.addr == ADDR_CMPB_L) begin
                next_compareB = {temp, bus.wrData};
            end else if (bus.addr == ADDR_IRQ_MASK) begin
                next_irqMask = bus.wrData;
            end
        end
        if (wrCntL) begin
            next_count = {temp, bus.wrData};
        end
        // ignored unless the mode takes top from the capture register
        if (wrCapL && topSrc == TOP_CAP) begin
            next_capture = {temp, bus.wrData};
        end

        // write-one or service clears; a same-cycle set still wins
        next_overflowFlag = ovfSet | (overflowFlag &
            ~((bus.wrStrobe && bus.addr == ADDR_IRQ_FLAGS &&
               bus.wrData[OVF_BIT]) || bus.ovfAck));
        next_captureFlag = captureEvent | (captureFlag &
            ~((bus.wrStrobe && bus.addr == ADDR_IRQ_FLAGS &&
               bus.wrData[CAP_BIT]) || bus.capAck));
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            controlRegA <= RST_BYTE;
            controlRegB <= RST_BYTE;
            irqMask <= RST_BYTE;
            count <= RST_WORD;
            capture <= RST_WORD;
            compareA <= RST_WORD;
            compareB <= RST_WORD;
            temp <= RST_BYTE;
            rdData <= RST_BYTE;
            countUp <= 1'b1;
            overflowFlag <= 1'b0;
            captureFlag <= 1'b0;
            topReached <= 1'b0;
            bottomReached <= 1'b0;
            divCnt <= '0;
        end else begin
            controlRegA <= next_controlRegA;
            controlRegB <= next_controlRegB;
            irqMask <= next_irqMask;
            count <= next_count;
            capture <= next_capture;
            compareA <= next_compareA;
            compareB <= next_compareB;
            temp <= next_temp;
            rdData <= next_rdData;
            countUp <= next_countUp;
            overflowFlag <= next_overflowFlag;
            captureFlag <= next_captureFlag;
            topReached <= next_topReached;
            bottomReached <= next_bottomReached;
            divCnt <= next_divCnt;
        end
    end

    // two-stage synchronisers, then one more stage for edge detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extSync <= 2'h0;
            pinSync <= 2'h0;
            cmpSync <= 2'h0;
            extPrev <= 1'b0;
            trigPrev <= 1'b0;
        end else begin
            extSync <= {extSync[0], extClockPin};
            pinSync <= {pinSync[0], capturePin};
            cmpSync <= {cmpSync[0], comparatorOut};
            extPrev <= extSync[1];
            trigPrev <= trigLevel;
        end
    end

    assign bus.rdData = rdData;
    assign bus.capIrq = captureFlag & irqMask[CAP_BIT];
    assign bus.ovfIrq = overflowFlag & irqMask[OVF_BIT];
    assign countValue = count;
endmodule : timer16_device

// >>> timer16_cpu.sv
// Purpose: CPU end that turns byte or word requests into bus strobes
// Assumes: the user side holds a request until reqReady is seen
// Notes: word accesses are never interleaved, so temp stays coherent
`timescale 1ns/1ps
module timer16_cpu (
    input wire logic ref_clk,
    input wire logic rst_n,
    timer_bus_if.cpu bus,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqWide,
    input wire logic [timer16_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [timer16_pkg::CNT_W-1:0] reqData,
    output logic reqReady,
    output logic respValid,
    output logic [timer16_pkg::CNT_W-1:0] respData,
    output logic capIrq,
    output logic ovfIrq,
    input wire logic capAck,
    input wire logic ovfAck
);
    import timer16_pkg::*;

    typedef enum logic [2:0] {
        IDLE,
        FIRST,
        SECOND,
        WAIT_RD,
        DONE
    } cpu_state_t;

    cpu_state_t state, next_state;
    logic isWrite, next_isWrite;
    logic isWide, next_isWide;
    logic [7:0] baseAddr, next_baseAddr;
    logic [15:0] data, next_data;

    always_comb begin
        next_state = state;
        next_isWrite = isWrite;
        next_isWide = isWide;
        next_baseAddr = baseAddr;
        next_data = data;
        case (state)
            IDLE: begin
                if (reqValid) begin
                    next_isWrite = reqWrite;
                    next_isWide = reqWide;
                    next_baseAddr = reqAddr;
                    next_data = reqWrite ? reqData : 16'h0000;
                    next_state = FIRST;
                end
            end
            // one request at a time keeps each byte pair atomic
            FIRST: begin
                if (isWide) begin
                    next_state = SECOND;
                end else begin
                    next_state = isWrite ? DONE : WAIT_RD;
                end
            end
            SECOND: begin
                if (!isWrite) begin
                    next_data[7:0] = bus.rdData;
                end
                next_state = isWrite ? DONE : WAIT_RD;
            end
            WAIT_RD: begin
                if (isWide) begin
                    next_data[15:8] = bus.rdData;
                end else begin
                    next_data = {8'h00, bus.rdData};
                end
                next_state = DONE;
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            isWrite <= 1'b0;
            isWide <= 1'b0;
            baseAddr <= RST_BYTE;
            data <= RST_WORD;
        end else begin
            state <= next_state;
            isWrite <= next_isWrite;
            isWide <= next_isWide;
            baseAddr <= next_baseAddr;
            data <= next_data;
        end
    end

    // word write: high byte first; word read: low byte first
    always_comb begin
        bus.wrStrobe = 1'b0;
        bus.rdStrobe = 1'b0;
        bus.addr = baseAddr;
        bus.wrData = data[7:0];
        if (state == FIRST) begin
            bus.wrStrobe = isWrite;
            bus.rdStrobe = ~isWrite;
            if (isWide && isWrite) begin
                bus.addr = baseAddr + 8'h01;
                bus.wrData = data[15:8];
            end
        end else if (state == SECOND) begin
            bus.wrStrobe = isWrite;
            bus.rdStrobe = ~isWrite;
            if (!isWrite) begin
                bus.addr = baseAddr + 8'h01;
            end
        end
    end

    assign reqReady = state == IDLE;
    assign respValid = state == DONE;
    assign respData = data;
    assign capIrq = bus.capIrq;
    assign ovfIrq = bus.ovfIrq;
    assign bus.capAck = capAck;
    assign bus.ovfAck = ovfAck;
endmodule : timer16_cpu

// >>> timer16_asserts.sv
// Purpose: bus checks between the CPU end and the timer
// Assumes: single clock, one-cycle strobes
// Notes: temp is tracked only until a count or capture low read
`timescale 1ns/1ps
module timer16_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic capIrq,
    input wire logic ovfIrq,
    input wire logic capAck,
    input wire logic ovfAck
);
    import timer16_pkg::*;
    logic [7:0] hiSeen, next_hiSeen;
    logic hiKnown, next_hiKnown, capMask, next_capMask, hiWr;
    assign hiWr = wrStrobe && addr[0] && addr >= ADDR_CNT_H
        && addr <= ADDR_CMPB_H;
    always_comb begin
        next_hiSeen = hiSeen;
        next_hiKnown = hiKnown;
        next_capMask = capMask;
        if (hiWr) begin
            next_hiSeen = wrData;
            next_hiKnown = 1'b1;
        end
        // low reads reload temp from a count or capture the checker cannot see
        if (rdStrobe && (addr == ADDR_CNT_L || addr == ADDR_CAP_L)) begin
            next_hiKnown = 1'b0;
        end
        if (wrStrobe && addr == ADDR_IRQ_MASK) begin
            next_capMask = wrData[CAP_BIT];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hiSeen <= 8'h00;
            hiKnown <= 1'b0;
            capMask <= 1'b0;
        end else begin
            hiSeen <= next_hiSeen;
            hiKnown <= next_hiKnown;
            capMask <= next_capMask;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence capHiWr;
        wrStrobe && addr == ADDR_CAP_H;
    endsequence
    sequence capLoWr;
        wrStrobe && addr == ADDR_CAP_L;
    endsequence
    temp_readback_a: assert property (
        rdStrobe && hiKnown && (addr == ADDR_CNT_H || addr == ADDR_CAP_H)
        |=> rdData == hiSeen) else $error("high read not from temp");
    cap_wr_order_a: assert property (capHiWr |=> capLoWr)
        else $error("capture low write does not follow high");
    cap_rd_order_a: assert property (
        rdStrobe && addr == ADDR_CAP_L |=> rdStrobe && addr == ADDR_CAP_H)
        else $error("capture high read does not follow low");
    cap_ack_a: assert property (capAck |=> !capIrq)
        else $error("capture request stays after service");
    flag_w1c_a: assert property (
        wrStrobe && addr == ADDR_IRQ_FLAGS && wrData[CAP_BIT] |=> !capIrq)
        else $error("capture flag not cleared by one");
    mask_off_a: assert property (
        wrStrobe && addr == ADDR_IRQ_MASK && !wrData[CAP_BIT] |=> !capIrq)
        else $error("capture request while masked");
    irq_masked_a: assert property (capIrq |-> capMask)
        else $error("capture request without enable");
    ovf_ack_a: assert property (ovfAck |=> !ovfIrq)
        else $error("overflow request stays after service");
endmodule : timer16_asserts

// >>> timer16_counter_capture_tb.sv
// Purpose: self-checking bench for the timer and its CPU end
// Assumes: all register traffic goes through the CPU user port
// Notes: ticks come from the system clock select, bar one external-edge check, to keep runs short
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
    fail_count++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module timer16_counter_capture_tb;
    import timer16_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqWide = 1'b0;
    logic [7:0] reqAddr = 8'h00;
    logic [15:0] reqData = 16'h0000;
    logic capAck = 1'b0, ovfAck = 1'b0, capPin = 1'b0, cmpOut = 1'b0;
    logic extPin = 1'b0;
    logic reqReady, respValid, capIrq, ovfIrq, topHit, botHit;
    logic [15:0] respData, countValue, r, c0;
    int fail_count = 0;
    int num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    timer_bus_if busIf ();
    timer16_device timer16_device_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus(busIf), .capturePin(capPin), .comparatorOut(cmpOut),
        .extClockPin(extPin), .countValue(countValue),
        .topReached(topHit), .bottomReached(botHit));
    timer16_cpu timer16_cpu_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus(busIf), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqWide(reqWide), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .respValid(respValid), .respData(respData),
        .capIrq(capIrq), .ovfIrq(ovfIrq), .capAck(capAck), .ovfAck(ovfAck));
    timer16_asserts timer16_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .addr(busIf.addr), .wrData(busIf.wrData), .rdData(busIf.rdData),
        .wrStrobe(busIf.wrStrobe), .rdStrobe(busIf.rdStrobe),
        .capIrq(busIf.capIrq), .ovfIrq(busIf.ovfIrq),
        .capAck(busIf.capAck), .ovfAck(busIf.ovfAck));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task automatic xfer(input logic w, input logic wd, input logic [7:0] a,
            input logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqWide <= wd;
        reqAddr <= a;
        reqData <= d;
        @(posedge ref_clk);
        reqValid <= 1'b0;
        @(negedge ref_clk);
        while (respValid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        r = respData;
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
    endtask : xfer
    // narrow reads compare the low byte only; the upper half is unused
    task automatic rdchk(input logic wd, input logic [7:0] a,
            input logic [15:0] ex, input string nm);
        xfer(1'b0, wd, a, 16'h0000);
        `CHK(nm, ex, wd ? r : {8'h00, r[7:0]})
    endtask : rdchk
    task automatic pulseAck(input logic cap);
        @(posedge ref_clk);
        capAck <= cap;
        ovfAck <= !cap;
        @(posedge ref_clk);
        capAck <= 1'b0;
        ovfAck <= 1'b0;
        @(negedge ref_clk);
    endtask : pulseAck
    task automatic waitIrq(input logic [1:0] sel);
        logic [3:0] lv;
        int i;
        lv = {botHit, topHit, capIrq, ovfIrq};
        for (i = 0; i < 60 && lv[sel] !== 1'b1; i++) begin
            @(negedge ref_clk);
            lv = {botHit, topHit, capIrq, ovfIrq};
        end
        if (i >= 60) begin
            fail_count++;
            give_verdict();
        end
    endtask : waitIrq
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(1'b1, ADDR_CNT_L, RST_WORD, "count");
        rdchk(1'b1, ADDR_CAP_L, RST_WORD, "capture");
        rdchk(1'b0, ADDR_CTRL_B, 16'h0000, "source");
        rdchk(1'b0, 8'h3F, 16'h0000, "unmapped");
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h01FF);
        repeat (20) @(negedge ref_clk);
        rdchk(1'b1, ADDR_CNT_L, 16'h01FF, "stopped");
        xfer(1'b1, 1'b0, ADDR_CNT_H, 16'h00AB);
        rdchk(1'b0, ADDR_CNT_H, 16'h00AB, "temp");
        `CHK("held", 16'h01FF, countValue)
        xfer(1'b1, 1'b0, ADDR_CTRL_B, {13'h0, CS_EXT_RISE});
        @(posedge ref_clk) extPin <= 1'b1;
        repeat (6) @(negedge ref_clk);
        `CHK("ext", 16'h0200, countValue)
        xfer(1'b1, 1'b0, ADDR_CTRL_B, 16'h0000);
        xfer(1'b1, 1'b0, ADDR_CNT_L, 16'h0012);
        `CHK("commit", 16'hAB12, countValue)
        xfer(1'b1, 1'b0, ADDR_CNT_L, 16'h0034);
        `CHK("reuse", 16'hAB34, countValue)
        xfer(1'b1, 1'b1, ADDR_CMPA_L, 16'h5A66);
        rdchk(1'b0, ADDR_CNT_L, 16'h0034, "low");
        rdchk(1'b0, ADDR_CMPA_H, 16'h005A, "cmp");
        rdchk(1'b0, ADDR_CNT_H, 16'h00AB, "latch");
        $display("done byte access");
        xfer(1'b1, 1'b0, ADDR_CTRL_B, {13'h0, CS_SYS});
        c0 = countValue;
        @(negedge ref_clk);
        `CHK("tick", c0 + 16'h0001, countValue)
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h0100);
        rdchk(1'b1, ADDR_CNT_L, 16'h0102, "running");
        `CHK("wins", 1'b1, (r - 16'h0100) < 16'h0010)
        xfer(1'b1, 1'b0, ADDR_IRQ_MASK, 16'h0001);
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'hFFF8);
        waitIrq(2'h0);
        `CHK("ovf", 1'b1, ovfIrq)
        pulseAck(1'b0);
        `CHK("ovfclr", 1'b0, ovfIrq)
        xfer(1'b1, 1'b0, ADDR_CTRL_A, 16'h0001);
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h00F8);
        waitIrq(2'h2);
        repeat (2) @(negedge ref_clk);
        c0 = countValue;
        @(negedge ref_clk);
        `CHK("down", c0 - 16'h0001, countValue)
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h0004);
        waitIrq(2'h3);
        `CHK("botovf", 1'b1, ovfIrq)
        xfer(1'b1, 1'b0, ADDR_CTRL_B, 16'h0000);
        xfer(1'b1, 1'b0, ADDR_CTRL_A, 16'h0000);
        $display("done counting");
        xfer(1'b1, 1'b0, ADDR_IRQ_MASK, 16'h0020);
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h1234);
        xfer(1'b1, 1'b0, ADDR_CTRL_B, 16'h0040);
        @(posedge ref_clk) capPin <= 1'b1;
        waitIrq(2'h1);
        `CHK("capirq", 1'b1, capIrq)
        rdchk(1'b1, ADDR_CAP_L, 16'h1234, "cap");
        xfer(1'b1, 1'b1, ADDR_CNT_L, 16'h2222);
        @(posedge ref_clk) capPin <= 1'b0;
        repeat (8) @(negedge ref_clk);
        rdchk(1'b1, ADDR_CAP_L, 16'h1234, "wrongedge");
        xfer(1'b1, 1'b0, ADDR_IRQ_FLAGS, 16'h0020);
        `CHK("w1c", 1'b0, capIrq)
        xfer(1'b1, 1'b0, ADDR_CTRL_B, 16'h0060);
        @(posedge ref_clk) cmpOut <= 1'b1;
        repeat (8) @(negedge ref_clk);
        rdchk(1'b1, ADDR_CAP_L, 16'h2222, "cmpcap");
        xfer(1'b1, 1'b0, ADDR_IRQ_MASK, 16'h0000);
        `CHK("masked", 1'b0, capIrq)
        xfer(1'b1, 1'b0, ADDR_IRQ_MASK, 16'h0020);
        pulseAck(1'b1);
        `CHK("serviced", 1'b0, capIrq)
        xfer(1'b1, 1'b1, ADDR_CAP_L, 16'hBEEF);
        rdchk(1'b1, ADDR_CAP_L, 16'h2222, "locked");
        xfer(1'b1, 1'b0, ADDR_CTRL_B, 16'h0018);
        xfer(1'b1, 1'b1, ADDR_CAP_L, 16'h0100);
        rdchk(1'b1, ADDR_CAP_L, 16'h0100, "captop");
        $display("done capture");
        give_verdict();
    end
endmodule : timer16_counter_capture_tb
